// *** bsc_pkg.sv ***
/*
  Shared constants and types of the boot serial command handler.
  Assumes byte-level framing is done by a receiver and transmitter outside.
*/
`default_nettype none

package bsc_pkg;

  // ------------------------------------------------------------------
  // Protocol bytes
  // ------------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE  = 8'h86;
  localparam logic [7:0] CMD_RAM    = 8'h10;
  localparam logic [7:0] CMD_SUM    = 8'h20;
  localparam logic [7:0] CMD_INFO   = 8'h30;
  localparam logic [7:0] CMD_ERASE  = 8'h40;
  localparam logic [7:0] ACK_OK     = 8'h10;
  localparam logic [7:0] ACK_RXERR  = 8'h18;
  localparam logic [7:0] ACK_BAD    = 8'h11;
  localparam logic [3:0] NIB_RXERR  = 4'h8;
  localparam logic [3:0] NIB_CMDERR = 4'h1;
  localparam logic [7:0] LAST_CMD_RST = 8'h00;

  // ------------------------------------------------------------------
  // Field lengths and counts
  // ------------------------------------------------------------------
  localparam logic [6:0] PWD_CHK_IDX  = 7'h0C;
  localparam logic [6:0] HDR_CHK_IDX  = 7'h06;
  localparam logic [6:0] SUM_CHK_IDX  = 7'h02;
  localparam logic [6:0] INFO_CHK_IDX = 7'h4F;
  localparam int         FIFO_DEPTH   = 32;
  localparam int         FIFO_WIDTH   = 9;

  // ------------------------------------------------------------------
  // Product information layout, byte offsets from reply byte 5
  // ------------------------------------------------------------------
  localparam logic [6:0] INFO_VER  = 7'h00;
  localparam logic [6:0] INFO_NAME = 7'h04;
  localparam logic [6:0] INFO_PWDA = 7'h10;
  localparam logic [6:0] INFO_RAMS = 7'h14;
  localparam logic [6:0] INFO_UEND = 7'h18;
  localparam logic [6:0] INFO_RAME = 7'h1C;
  localparam logic [6:0] INFO_DUMY = 7'h20;
  localparam logic [31:0] PWD_START_ADDR = 32'h0008FEF4;
  localparam logic [31:0] RAM_START_ADDR = 32'h00000400;
  localparam logic [31:0] RAM_USER_END   = 32'h00006BFF;
  localparam logic [31:0] RAM_END_ADDR   = 32'h000083FF;
  // Arbitrary twelve-character name, first character in the top byte
  localparam logic [95:0] PRODUCT_NAME   = 96'h424F4F544C4F414445523031;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } bsc_rx_byte_t;

  typedef enum logic [3:0] {
    ST_SYNC    = 4'b0000,
    ST_CMD     = 4'b0001,
    ST_PWD     = 4'b0010,
    ST_HDR     = 4'b0011,
    ST_DATA    = 4'b0100,
    ST_DSUM    = 4'b0101,
    ST_SUMWAIT = 4'b0110,
    ST_SUMTX   = 4'b0111,
    ST_INFO    = 4'b1000,
    ST_JUMP    = 4'b1001,
    ST_HALT    = 4'b1010
  } bsc_state_t;

endpackage

`default_nettype wire

// *** bsc_handler.sv ***
/*
  Boot serial command handler with its receive FIFO.
  Assumes a receiver on core_clk delivering bytes with an error flag, a
  transmitter taking bytes by valid/ready, and outside engines for the
  password compare and the flash sum.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Header bytes 19-22 give the RAM start address, most significant first.
// - Bytes 23-24 give the 16-bit byte count, high byte first.
// - Receive error in header bytes: reply 18H, then await a command.
// - Header sum with checksum nonzero: reply 11H, then await a command.
// - Clean header with zero sum: reply 10H.
// - Payload bytes stored at consecutive addresses from start, count bytes.
// - Payload reply: 18H on error, 11H on bad sum, else 10H.
// - After payload 10H is sent, branch to the start address.
// - Command 20H is echoed and starts the flash sum.
// - Command error replies X8H, unknown command X1H, old upper nibble.
// - Sum reply: high byte, low byte, negated sum of both.
// - Byte after the sum checksum is the next command.
// - Command 30H is echoed before the information block.
// - Info bytes 5-8 are the four flash version bytes.
// - Info bytes 9-20 are the product name in ASCII.
// - Info bytes 21-24 are F4H, FEH, 08H, 00H.
// - Info bytes 25-28 are 00H, 04H, 00H, 00H.
// - Info bytes 29-32 are the RAM user end address 006BFFH.
// - Info bytes 33-36 are FFH, 83H, 00H, 00H.
// - Session opens with 86H; a match replies 86H, otherwise silence.
// - Acknowledge bit 3 marks receive error, bit 0 other errors, bits 2-1 zero.

// ----------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------
module bsc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      level_q;
  logic             push;
  logic             popOut;

  assign inReady  = (level_q != (AW+1)'(DEPTH));
  assign outValid = (level_q != '0);
  assign push     = inValid && inReady;
  assign popOut   = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (popOut)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !popOut)
      begin
        level_q <= level_q + 1'b1;
      end
      else if (popOut && !push)
      begin
        level_q <= level_q - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------------
// Command handler
// ----------------------------------------------------------------------
module bsc_handler
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Received bytes
  input  wire logic         rxValid,
  output logic              rxReady,
  input  wire bsc_rx_byte_t rxByte,
  // Transmitted bytes
  output logic              txValid,
  input  wire logic         txReady,
  output logic [7:0]        txData,
  // Password compare result
  input  wire logic         pwdMatch,
  // RAM write port
  output logic              ramWe,
  input  wire logic         ramReady,
  output logic [31:0]       ramAddr,
  output logic [7:0]        ramWrData,
  // Flash data and sum engine
  input  wire logic [31:0]  versionId,
  output logic              sumStart,
  input  wire logic         sumDone,
  input  wire logic [15:0]  sumValue,
  // Branch to loaded code
  output logic              jumpValid,
  output logic [31:0]       jumpAddr
);

  // --------------------------------------------------------------------
  // Information block byte lookup
  // --------------------------------------------------------------------
  function automatic logic [7:0] infoByte(input logic [6:0] idx, input logic [31:0] ver);
    logic [6:0] k;
    k = idx;
    infoByte = 8'h00;
    if (idx < INFO_NAME)
    begin
      infoByte = ver[{k[1:0], 3'b000} +: 8];
    end
    else if (idx < INFO_PWDA)
    begin
      k = 7'(INFO_PWDA - 7'h01 - idx);
      infoByte = PRODUCT_NAME[{k[3:0], 3'b000} +: 8];
    end
    // addresses go out least significant byte first
    else if (idx < INFO_DUMY)
    begin
      k = 7'(idx - INFO_PWDA);
      case (k[4:2])
        3'h0:    infoByte = PWD_START_ADDR[{k[1:0], 3'b000} +: 8];
        3'h1:    infoByte = RAM_START_ADDR[{k[1:0], 3'b000} +: 8];
        3'h2:    infoByte = RAM_USER_END[{k[1:0], 3'b000} +: 8];
        3'h3:    infoByte = RAM_END_ADDR[{k[1:0], 3'b000} +: 8];
        default: infoByte = 8'h00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Receive FIFO
  // --------------------------------------------------------------------
  bsc_rx_byte_t fOut;
  logic         fValid;
  logic         pop;
  logic         canTake;

  bsc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) uFifo (
    .core_clk (core_clk),
    .rstn     (rstn),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .inData   (rxByte),
    .outValid (fValid),
    .outReady (canTake),
    .outData  (fOut)
  );

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  bsc_state_t  state_q;
  logic [6:0]  cnt_q;
  logic [7:0]  acc_q;
  logic        err_q;
  logic [7:0]  lastCmd_q;
  logic [47:0] hdr_q;
  logic [31:0] startAddr_q;
  logic [31:0] wrAddr_q;
  logic [15:0] remain_q;
  logic [15:0] sum_q;
  logic        txValid_q;
  logic [7:0]  txData_q;
  logic        txIsAck_q;
  logic        ramWe_q;
  logic [31:0] ramAddr_q;
  logic [7:0]  ramData_q;
  logic        sumStart_q;
  logic        jump_q;
  logic        txFire;
  logic        txLoad;
  logic        txAck;
  logic [7:0]  txByte;
  logic [7:0]  chkAck;
  logic [7:0]  sumNext;
  logic        known;
  logic [7:0]  info;

  assign txFire  = txValid_q && txReady;
  assign pop     = fValid && canTake;
  assign sumNext = 8'(acc_q + fOut.data);
  assign known   = (fOut.data == CMD_RAM) || (fOut.data == CMD_SUM) ||
                   (fOut.data == CMD_INFO) || (fOut.data == CMD_ERASE);
  assign info    = infoByte(cnt_q, versionId);

  // reply codes only ever raise bit 3 or bit 0
  // errors in any byte of the block win over the sum check
  always_comb
  begin
    if (err_q || fOut.err)
    begin
      chkAck = ACK_RXERR;
    end
    // nonzero modulo-256 sum, or a failed password, is a checksum error
    else if (sumNext != 8'h00 || (state_q == ST_PWD && !pwdMatch))
    begin
      chkAck = ACK_BAD;
    end
    else
    begin
      chkAck = ACK_OK;
    end
  end

  // Take a byte once the previous reply has left, or in ST_DATA once the RAM write is taken, so replies keep order
  always_comb
  begin
    case (state_q)
      ST_SYNC, ST_CMD, ST_PWD, ST_HDR, ST_DSUM: canTake = !txValid_q;
      ST_DATA:                                  canTake = !ramWe_q || ramReady;
      default:                                  canTake = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Reply selection
  // --------------------------------------------------------------------
  always_comb
  begin
    txLoad = 1'b0;
    txAck  = 1'b0;
    txByte = 8'h00;
    case (state_q)
      // answer only a clean sync byte
      ST_SYNC:
      begin
        txLoad = pop && !fOut.err && (fOut.data == SYNC_BYTE);
        txByte = SYNC_BYTE;
      end
      // error codes keep the previous command's upper nibble
      ST_CMD:
      begin
        txLoad = pop;
        txAck  = 1'b1;
        if (fOut.err)
        begin
          txByte = {lastCmd_q[7:4], NIB_RXERR};
        end
        else if (known)
        begin
          txByte = fOut.data;
        end
        else
        begin
          txByte = {lastCmd_q[7:4], NIB_CMDERR};
        end
      end
      ST_PWD:
      begin
        txLoad = pop && (cnt_q == PWD_CHK_IDX);
        txAck  = 1'b1;
        txByte = chkAck;
      end
      ST_HDR:
      begin
        txLoad = pop && (cnt_q == HDR_CHK_IDX);
        txAck  = 1'b1;
        txByte = chkAck;
      end
      ST_DSUM:
      begin
        txLoad = pop;
        txAck  = 1'b1;
        txByte = chkAck;
      end
      // high, low, then negated sum of both
      ST_SUMTX:
      begin
        txLoad = !txValid_q;
        case (cnt_q[1:0])
          2'h0:    txByte = sum_q[15:8];
          2'h1:    txByte = sum_q[7:0];
          default: txByte = 8'(8'h00 - sum_q[15:8] - sum_q[7:0]);
        endcase
      end
      ST_INFO:
      begin
        txLoad = !txValid_q;
        txByte = (cnt_q == INFO_CHK_IDX) ? 8'(8'h00 - acc_q) : info;
      end
      default:
      begin
        txLoad = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Transmit holding register
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      txValid_q <= 1'b0;
      txData_q  <= 8'h00;
      txIsAck_q <= 1'b0;
    end
    else if (txLoad)
    begin
      txValid_q <= 1'b1;
      txData_q  <= txByte;
      txIsAck_q <= txAck;
    end
    else if (txFire)
    begin
      txValid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Command sequencing
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q     <= ST_SYNC;
      cnt_q       <= 7'h00;
      acc_q       <= 8'h00;
      err_q       <= 1'b0;
      lastCmd_q   <= LAST_CMD_RST;
      hdr_q       <= 48'h0;
      startAddr_q <= 32'h0;
      wrAddr_q    <= 32'h0;
      remain_q    <= 16'h0;
      sum_q       <= 16'h0;
      sumStart_q  <= 1'b0;
      jump_q      <= 1'b0;
    end
    else
    begin
      sumStart_q <= 1'b0;
      jump_q     <= 1'b0;
      cnt_q      <= (pop || state_q == ST_SUMTX || state_q == ST_INFO) &&
                    (pop || !txValid_q) ? cnt_q + 7'h01 : cnt_q;
      acc_q      <= pop ? sumNext : acc_q;
      err_q      <= err_q || (pop && fOut.err);
      case (state_q)
        // silence until a clean sync byte
        ST_SYNC:
        begin
          if (txLoad)
          begin
            state_q <= ST_CMD;
          end
        end
        ST_CMD:
        begin
          cnt_q <= 7'h00;
          acc_q <= 8'h00;
          err_q <= 1'b0;
          if (pop && !fOut.err)
          begin
            lastCmd_q <= fOut.data;
          end
          if (pop && !fOut.err && fOut.data == CMD_RAM)
          begin
            state_q <= ST_PWD;
          end
          // echo and start the sum engine
          else if (pop && !fOut.err && fOut.data == CMD_SUM)
          begin
            state_q    <= ST_SUMWAIT;
            sumStart_q <= 1'b1;
          end
          else if (pop && !fOut.err && fOut.data == CMD_INFO)
          begin
            state_q <= ST_INFO;
          end
        end
        ST_PWD, ST_HDR:
        begin
          if (pop && state_q == ST_HDR)
          begin
            // big-endian shift of address then count
            hdr_q <= {hdr_q[39:0], fOut.data};
          end
          if (txLoad)
          begin
            cnt_q <= 7'h00;
            acc_q <= 8'h00;
            err_q <= 1'b0;
            if (chkAck != ACK_OK)
            begin
              state_q <= ST_CMD;
            end
            else if (state_q == ST_PWD)
            begin
              state_q <= ST_HDR;
            end
            else
            begin
              startAddr_q <= hdr_q[47:16];
              wrAddr_q    <= hdr_q[47:16];
              remain_q    <= hdr_q[15:0];
              state_q     <= (hdr_q[15:0] == 16'h0) ? ST_DSUM : ST_DATA;
            end
          end
        end
        // consecutive addresses until the count is used up
        ST_DATA:
        begin
          if (pop)
          begin
            wrAddr_q <= wrAddr_q + 32'h1;
            remain_q <= remain_q - 16'h1;
            if (remain_q == 16'h1)
            begin
              state_q <= ST_DSUM;
            end
          end
        end
        // any failure goes back to command wait
        ST_DSUM:
        begin
          if (pop)
          begin
            state_q <= (chkAck == ACK_OK) ? ST_JUMP : ST_CMD;
          end
        end
        ST_SUMWAIT:
        begin
          cnt_q <= 7'h00;
          if (sumDone)
          begin
            sum_q   <= sumValue;
            state_q <= ST_SUMTX;
          end
        end
        // after the sum checksum the next byte is a command
        ST_SUMTX:
        begin
          if (!txValid_q && cnt_q == SUM_CHK_IDX)
          begin
            state_q <= ST_CMD;
          end
        end
        ST_INFO:
        begin
          if (!txValid_q)
          begin
            acc_q <= 8'(acc_q + info);
            if (cnt_q == INFO_CHK_IDX)
            begin
              state_q <= ST_CMD;
            end
          end
        end
        // branch once the final 10H has left and RAM is written
        ST_JUMP:
        begin
          if (!txValid_q && !ramWe_q)
          begin
            jump_q  <= 1'b1;
            state_q <= ST_HALT;
          end
        end
        ST_HALT:
        begin
          state_q <= ST_HALT;
        end
        default:
        begin
          state_q <= ST_SYNC;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // RAM write port
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ramWe_q   <= 1'b0;
      ramAddr_q <= 32'h0;
      ramData_q <= 8'h00;
    end
    // payload byte goes to the running address
    else if (pop && state_q == ST_DATA)
    begin
      ramWe_q   <= 1'b1;
      ramAddr_q <= wrAddr_q;
      ramData_q <= fOut.data;
    end
    else if (ramReady)
    begin
      ramWe_q <= 1'b0;
    end
  end

  assign txValid   = txValid_q;
  assign txData    = txData_q;
  assign ramWe     = ramWe_q;
  assign ramAddr   = ramAddr_q;
  assign ramWrData = ramData_q;
  assign sumStart  = sumStart_q;
  assign jumpValid = jump_q;
  assign jumpAddr  = startAddr_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [31:0] prevRamAddr_q;
  logic        ramSeen_q;

  always_ff @(posedge core_clk)
  begin
    if (!rstn || state_q != ST_DATA)
    begin
      ramSeen_q     <= 1'b0;
      prevRamAddr_q <= 32'h0;
    end
    else if (pop)
    begin
      ramSeen_q     <= 1'b1;
      prevRamAddr_q <= wrAddr_q;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_sync_silent: assert property (
    state_q == ST_SYNC && pop && fOut.data != SYNC_BYTE |=> !txValid_q)
    else $error("reply sent to a bad sync byte");
  a_ack_zero_bits: assert property (
    txValid_q && txIsAck_q |-> txData_q[2:1] == 2'b00)
    else $error("acknowledge bits 2-1 not zero");
  a_cmd_err_nibble: assert property (
    state_q == ST_CMD && pop && fOut.err
    |=> txValid_q && txData_q == {$past(lastCmd_q[7:4]), NIB_RXERR})
    else $error("command error reply wrong");
  a_cmd_unknown: assert property (
    state_q == ST_CMD && pop && !fOut.err && !known |=> txData_q[3:0] == NIB_CMDERR)
    else $error("unknown command reply wrong");
  a_hdr_rx_err: assert property (
    state_q == ST_HDR && pop && cnt_q == HDR_CHK_IDX && (err_q || fOut.err)
    |=> txData_q == ACK_RXERR && state_q == ST_CMD)
    else $error("header receive error not answered 18H");
  a_ram_consec: assert property (
    state_q == ST_DATA && pop && ramSeen_q |-> wrAddr_q == prevRamAddr_q + 32'h1)
    else $error("payload addresses not consecutive");
  a_sum_chk: assert property (
    state_q == ST_SUMTX && txLoad && cnt_q == SUM_CHK_IDX
    |=> 8'(txData_q + sum_q[15:8] + sum_q[7:0]) == 8'h00)
    else $error("sum reply checksum wrong");
  a_jump_after_ack: assert property (
    jumpValid |-> $past(state_q) == ST_JUMP && !$past(txValid_q) && !$past(ramWe_q) &&
    jumpAddr == startAddr_q)
    else $error("branch not after final acknowledge");
  a_info_user_end: assert property (
    state_q == ST_INFO && txLoad && cnt_q == INFO_UEND
    |=> txData_q == RAM_USER_END[7:0])
    else $error("user end address byte wrong");
  a_tx_hold: assert property (
    txValid_q && !txReady |=> txValid_q && $stable(txData_q))
    else $error("reply byte changed before taken");

  c_ram_jump:  cover property (jumpValid);
  c_sum_done:  cover property (state_q == ST_SUMTX ##1 state_q == ST_CMD);
  c_info_done: cover property (state_q == ST_INFO ##1 state_q == ST_CMD);
  c_cmd_err:   cover property (state_q == ST_CMD && pop && fOut.err);

endmodule

`default_nettype wire

// *** bsc_host_model.sv ***
/* Far-side model: byte sink, RAM port and flash sum engine.
   Assumes the handler's core_clk and rstn. */
`timescale 1ns/10ps
`default_nettype none
module bsc_host_model (
  // Clock, reset, pace
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic slow,
  // Sum request
  input  wire logic sumStart,
  // Answers
  output logic      txReady,
  output logic      ramReady,
  output logic      sumDone
);
  logic [7:0] rnd_q;
  logic [2:0] dly_q;
  // Slow mode stalls sink and RAM at random so the FIFO backs up
  always_ff @(posedge core_clk)
  begin
    rnd_q    <= rstn ? {rnd_q[6:0], ^(rnd_q & 8'hB8)} : 8'hA7;
    txReady  <= !slow || rnd_q[0];
    ramReady <= !slow || rnd_q[3];
    dly_q    <= {dly_q[1:0], sumStart && rstn};
    sumDone  <= dly_q[2];
  end
endmodule
`default_nettype wire

// *** bsc_handler_tb.sv ***
/* Self-checking bench of the command handler.
   Assumes the host model is compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module bsc_handler_tb;
  import bsc_pkg::*;
  logic         core_clk, rstn, rxValid, rxReady, txValid, txReady, pwdMatch;
  logic         ramWe, ramReady, sumStart, sumDone, jumpValid, slow;
  logic [7:0]   txData, ramWrData, s, d;
  logic [31:0]  ramAddr, versionId, jumpAddr, seed, start;
  logic [15:0]  sumValue, cnt;
  logic [47:0]  hdr;
  bsc_rx_byte_t rxByte;
  logic [7:0]   got[$];
  logic [39:0]  wexp[$];
  int           error_cnt, samples_checked, jumps;

  bsc_handler i_bsc_handler (.core_clk, .rstn, .rxValid, .rxReady, .rxByte, .txValid,
    .txReady, .txData, .pwdMatch, .ramWe, .ramReady, .ramAddr, .ramWrData, .versionId,
    .sumStart, .sumDone, .sumValue, .jumpValid, .jumpAddr);
  bsc_host_model i_bsc_host_model (.core_clk, .rstn, .slow, .sumStart, .txReady,
    .ramReady, .sumDone);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reply byte k of the information block, 5 to 84
  function automatic logic [7:0] info(input int k);
    logic [127:0] adr = {32'h000083FF, 32'h00006BFF, 32'h00000400, 32'h0008FEF4};
    logic [7:0]   r = 8'h00;
    if (k == 84)
      for (int j = 5; j < 84; j++)
        r -= info(j);
    else if (k < 9)
      r = versionId[8*(k-5) +: 8];
    else if (k < 21)
      r = PRODUCT_NAME[95-8*(k-9) -: 8];
    else if (k < 37)
      r = adr[8*(k-21) +: 8];
    return r;
  endfunction

  // One idle cycle between bytes keeps each strobe change in its own step
  task automatic send(input logic err, input logic [7:0] b);
    logic ok;
    @(negedge core_clk);
    rxValid = 1'b1;
    rxByte  = '{err, b};
    for (int i = 0; i < 4000; i++)
    begin
      #1 ok = rxReady;
      @(posedge core_clk);
      if (ok)
      begin
        @(negedge core_clk);
        rxValid = 1'b0;
        return;
      end
      @(negedge core_clk);
    end
    error_cnt++;
    print_verdict();
  endtask

  task automatic expect_reply(input string what, input logic [7:0] exp);
    for (int i = 0; i < 8000 && got.size() == 0; i++)
      @(posedge core_clk);
    if (got.size() == 0)
    begin
      error_cnt++;
      print_verdict();
    end
    else
      chk(what, exp, got.pop_front());
  endtask

  always @(posedge core_clk)
  begin
    if (txValid && txReady)
      got.push_back(txData);
    if (ramWe && ramReady)
      chk("ram write", wexp.pop_front(), {ramAddr, ramWrData});
    if (jumpValid)
    begin
      jumps++;
      chk("jump address", start, jumpAddr);
    end
  end

  initial
  begin
    seed = 32'h0000D0B5;
    {rstn, rxValid, rxByte, slow, jumps} = '0;
    pwdMatch  = 1'b1;
    versionId = xs();
    sumValue  = 16'(xs());
    repeat (12) @(negedge core_clk);
    chk("outputs in reset", 5'b00001, {txValid, ramWe, sumStart, jumpValid, rxReady});
    rstn = 1'b1;
    send(1'b0, 8'h86);
    expect_reply("sync echo", 8'h86);
    send(1'b0, 8'h55);
    expect_reply("unknown cmd", 8'h01);
    send(1'b1, 8'h20);
    expect_reply("cmd rx error", 8'h58);
    send(1'b0, 8'h20);
    expect_reply("sum echo", 8'h20);
    expect_reply("sum high", sumValue[15:8]);
    expect_reply("sum low", sumValue[7:0]);
    expect_reply("sum check", 8'(-(sumValue[15:8] + sumValue[7:0])));
    send(1'b0, 8'h77);
    expect_reply("cmd after sum", 8'h21);
    send(1'b0, 8'h40);
    expect_reply("erase echo", 8'h40);
    slow = 1'b1;
    send(1'b0, 8'h30);
    expect_reply("info echo", 8'h30);
    for (int k = 5; k <= 84; k++)
      expect_reply("info byte", info(k));
    // Rounds: password refused, header rx error, header bad sum, payload bad sum,
    // payload rx error, good
    for (int m = 0; m < 6; m++)
    begin
      pwdMatch = (m != 0);
      send(1'b0, 8'h10);
      expect_reply("ram echo", 8'h10);
      repeat (13) send(1'b0, 8'h00);
      expect_reply("password ack", m ? 8'h10 : 8'h11);
      if (m == 0)
        continue;
      start = 32'h00000400 + (xs() & 32'h00000FFF);
      cnt   = (m == 5) ? 16'h0028 : 16'h0000;
      hdr   = {start, cnt};
      s     = 8'h00;
      for (int i = 5; i >= 0; i--)
      begin
        s -= hdr[8*i +: 8];
        send(m == 1 && i == 2, hdr[8*i +: 8]);
      end
      send(1'b0, s + 8'(m == 2));
      expect_reply("header ack", m == 1 ? 8'h18 : m == 2 ? 8'h11 : 8'h10);
      if (m < 3)
        continue;
      s = 8'h00;
      for (int i = 0; i < cnt; i++)
      begin
        d = 8'(xs());
        s -= d;
        wexp.push_back({start + i, d});
        send(1'b0, d);
      end
      send(m == 4, s + 8'(m == 3));
      expect_reply("payload ack", m == 3 ? 8'h11 : m == 4 ? 8'h18 : 8'h10);
    end
    for (int i = 0; i < 200 && jumps == 0; i++)
      @(posedge core_clk);
    chk("jump count", 1, jumps);
    chk("writes left", 0, wexp.size());
    // Second reset mid-run: the halted handler must wait for sync again
    @(negedge core_clk);
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("outputs in reset", 5'b00001, {txValid, ramWe, sumStart, jumpValid, rxReady});
    rstn = 1'b1;
    send(1'b0, 8'h55);
    send(1'b0, 8'h86);
    expect_reply("sync after reset", 8'h86);
    send(1'b1, 8'h30);
    expect_reply("cmd error after reset", 8'h08);
    print_verdict();
  end
endmodule
`default_nettype wire
